// ==== rfa_record_unit.sv ====
// Record read, update and search engine for one elementary_file.
// Function
// - Read needs read access and returns one complete record.
// - A failed read leaves the record pointer untouched.
// - Current and absolute reads return the record, pointer unchanged.
// - Next read advances first; unset pointer reads and points record one.
// - Next read at last linear record keeps pointer, returns nothing.
// - Next read at last cyclic record wraps to first and reads it.
// - Previous read steps back first; unset pointer reads last record.
// - Previous read at first linear record keeps pointer, returns nothing.
// - Previous read at first cyclic record wraps to last and reads it.
// - P2 top five bits: zero is current file, else short_file_id 1..30.
// - P2 low bits: 010 next, 011 previous, 100 absolute; P1 zero current.
// - Update needs update access, replaces whole record, failure keeps pointer.
// - Current and absolute updates overwrite the record, pointer unchanged.
// - Next update advances then writes; at last linear record does nothing.
// - Previous linear update steps back then writes; at first does nothing.
// - Cyclic files accept only previous-mode updates.
// - Cyclic previous update writes oldest record, points at it, numbers it one.
// - Update carries Lc equal to data length and no Le.
// - Search needs read access; starts at byte one, offset, or occurrence.
// - Search returns matching record numbers up to Le; none if Le empty.
// - A successful search points at the first matching record.
// - Search P2 low bits: 100 forward, 101 backward, 110 enhanced, 111 own.
`timescale 1ns/10ps
`include "rfa_defines.svh"
module rfa_record_unit
	import rfa_pkg::*;
#(
	parameter int MAX_RECS = 16,
	parameter int MAX_LEN  = 32
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       cmd_valid,
	input  wire rfa_op_t    cmd_op,
	input  wire logic [7:0] cmd_p1,
	input  wire logic [7:0] cmd_p2,
	input  wire logic [7:0] cmd_lc,
	input  wire logic [7:0] cmd_le,
	input  wire logic       cmd_le_present,
	output logic            cmd_ready,
	input  wire logic       file_select,
	input  wire logic [4:0] file_short_file_id,
	input  wire logic       file_cyclic,
	input  wire logic [7:0] file_rec_count,
	input  wire logic [7:0] file_rec_len,
	input  wire logic       read_allowed,
	input  wire logic       update_allowed,
	input  wire logic       in_valid,
	input  wire logic [7:0] in_byte,
	output logic            in_ready,
	output logic            out_valid,
	output logic [7:0]      out_byte,
	output logic            out_last,
	output logic            done,
	output logic [3:0]      status,
	output logic [7:0]      rec_ptr
);
	localparam int AW = $clog2(MAX_RECS * MAX_LEN);

	logic [7:0] mem [MAX_RECS * MAX_LEN];
	logic [7:0] pat [MAX_LEN];
	rfa_state_t st_r;
	rfa_op_t    op_r;
	logic [7:0] ptr_r, nptr_r, tgt_r, phys_r, idx_r, newest_r, lc_r;
	logic [7:0] pos_r, val_r, pat_len_r, first_r, le_r;
	logic [8:0] found_r;
	logic [3:0] stat_r;
	logic       dir_r, enh_r, occ_r, find_r, le_pres_r, cyc_upd_r;
	logic       out_valid_r, out_last_r;
	logic [7:0] out_byte_r;
	logic [3:0] dec_st;
	logic [7:0] dec_tgt, dec_nptr;
	logic       file_ok, unset;
	logic [2:0] mode;
	logic [7:0] len, cnt, sphys, cur_byte;
	logic       hit, fits, adv, found_now, srch_last, emit;
	logic       rd_end, wr_end;

	// Logical record number to physical slot, rotated for cyclic files.
	function automatic logic [7:0] to_phys(input logic [7:0] n,
		input logic [7:0] newest, input logic [7:0] c, input logic cyc);
		logic [8:0] s;
		s = {1'b0, n} - 9'h001 + (cyc ? {1'b0, newest} : 9'h000);
		if (s >= {1'b0, c}) begin
			s = s - {1'b0, c};
		end
		return s[7:0];
	endfunction

	// Byte address of one byte of one physical record slot.
	function automatic logic [AW-1:0] to_addr(input logic [7:0] ph,
		input logic [7:0] i);
		return AW'(int'(ph) * MAX_LEN + int'(i));
	endfunction

	assign len  = file_rec_len;
	assign cnt  = file_rec_count;
	assign mode = cmd_p2[2:0];
	assign unset = (ptr_r == `RFA_PTR_UNSET);
	// Target is the current file or the matching short_file_id.
	assign file_ok = (cmd_p2[7:3] == `RFA_SFI_CURRENT) ||
		((cmd_p2[7:3] != `RFA_SFI_RFU) &&
		(cmd_p2[7:3] == file_short_file_id));

	// Resolves the target record and the pointer after success.
	always_comb begin
		dec_st   = `RFA_ST_OK;
		dec_tgt  = ptr_r;
		dec_nptr = ptr_r;
		if (!file_ok) begin
			dec_st = `RFA_ST_NO_FILE;
		end else if (cmd_op != RFA_OP_UPDATE && !read_allowed) begin
			dec_st = `RFA_ST_NO_ACCESS;
		end else if (cmd_op == RFA_OP_UPDATE && !update_allowed) begin
			dec_st = `RFA_ST_NO_ACCESS;
		end else if (cmd_op == RFA_OP_UPDATE &&
			(cmd_le_present || cmd_lc != len)) begin
			dec_st = `RFA_ST_BAD_LEN;
		end else if (cmd_op == RFA_OP_READ && cmd_le_present &&
			cmd_le != 8'h00 && cmd_le != len) begin
			dec_st = `RFA_ST_BAD_LEN;
		end else if (cmd_op == RFA_OP_UPDATE && file_cyclic &&
			mode != `RFA_MODE_PREV) begin
			dec_st = `RFA_ST_BAD_CMD;
		end else if (cmd_op == RFA_OP_SEARCH) begin
			if (mode == `RFA_SRCH_PROP) begin
				dec_st = `RFA_ST_BAD_CMD;
			end else if (!mode[2]) begin
				dec_st = `RFA_ST_BAD_P2;
			end else if (mode == `RFA_SRCH_ENH &&
				cmd_lc < `RFA_ENH_HDR_LEN) begin
				dec_st = `RFA_ST_BAD_LEN;
			end else if (int'(cmd_lc) > MAX_LEN +
				((mode == `RFA_SRCH_ENH) ? 2 : 0)) begin
				dec_st = `RFA_ST_BAD_LEN; // Pattern must fit the buffer.
			end else if (cmd_p1 == `RFA_P1_CURRENT) begin
				if (unset) begin
					dec_st = `RFA_ST_NOT_FOUND;
				end
			end else if (cmd_p1 > cnt) begin
				dec_st = `RFA_ST_NOT_FOUND;
			end else begin
				dec_tgt = cmd_p1;
			end
		end else if (cmd_op == RFA_OP_NONE) begin
			dec_st = `RFA_ST_BAD_CMD;
		end else begin
			unique case (mode)
				`RFA_MODE_NEXT: begin
					if (unset) begin
						dec_tgt = 8'h01;
					end else if (ptr_r < cnt) begin
						dec_tgt = ptr_r + 8'h01;
					end else if (file_cyclic) begin
						dec_tgt = 8'h01;
					end else begin
						dec_st = `RFA_ST_NOT_FOUND;
					end
					dec_nptr = dec_tgt;
				end
				`RFA_MODE_PREV: begin
					if (cmd_op == RFA_OP_UPDATE && file_cyclic) begin
						dec_tgt  = cnt;
						dec_nptr = 8'h01;
					end else begin
						if (unset) begin
							dec_tgt = cnt;
						end else if (ptr_r > 8'h01) begin
							dec_tgt = ptr_r - 8'h01;
						end else if (file_cyclic) begin
							dec_tgt = cnt;
						end else begin
							dec_st = `RFA_ST_NOT_FOUND;
						end
						dec_nptr = dec_tgt;
					end
				end
				`RFA_MODE_ABS: begin
					if (cmd_p1 == `RFA_P1_CURRENT) begin
						if (unset) begin
							dec_st = `RFA_ST_NOT_FOUND;
						end
					end else if (cmd_p1 > cnt) begin
						dec_st = `RFA_ST_NOT_FOUND;
					end else begin
						dec_tgt = cmd_p1;
					end
				end
				default: begin
					dec_st = `RFA_ST_BAD_P2;
				end
			endcase
		end
	end

	// Search datapath: pattern compare at the current position.
	assign sphys    = to_phys(tgt_r, newest_r, cnt, file_cyclic);
	assign cur_byte = mem[to_addr(sphys, pos_r)];
	assign fits = ({1'b0, pos_r} + {1'b0, pat_len_r}) <= {1'b0, len};
	always_comb begin
		hit = 1'b1;
		for (int k = 0; k < MAX_LEN; k++) begin
			if (k < int'(pat_len_r) && mem[to_addr(sphys,
				8'(int'(pos_r) + k))] != pat[k]) begin
				hit = 1'b0;
			end
		end
	end

	// One search step per cycle: find the start byte, then compare.
	always_comb begin
		adv       = 1'b0;
		found_now = 1'b0;
		if (st_r == SRCH) begin
			if (find_r) begin
				adv = (pos_r >= len);
			end else if (!fits) begin
				adv = 1'b1;
			end else if (hit) begin
				adv       = 1'b1;
				found_now = 1'b1;
			end
		end
	end
	assign srch_last = adv && (dir_r ? (tgt_r <= 8'h01) : (tgt_r >= cnt));
	// Only as many record numbers as Le allows; Le of zero means 256.
	assign emit = found_now && le_pres_r &&
		((le_r == 8'h00) ? (found_r < 9'h100) : (found_r < {1'b0, le_r}));
	assign rd_end = (st_r == RD) && (idx_r == len - 8'h01);
	assign wr_end = (st_r == WR) && in_valid && (idx_r == len - 8'h01);

	// Command sequencer.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_r <= IDLE;
		end else begin
			unique case (st_r)
				IDLE: begin
					if (cmd_valid) begin
						if (dec_st != `RFA_ST_OK) begin
							st_r <= FIN;
						end else if (cmd_op == RFA_OP_READ) begin
							st_r <= RD;
						end else if (cmd_op == RFA_OP_UPDATE) begin
							st_r <= WR;
						end else begin
							st_r <= (cmd_lc == 8'h00) ? SINIT : PAT;
						end
					end
				end
				RD:    st_r <= rd_end ? FIN : RD;
				WR:    st_r <= wr_end ? FIN : WR;
				PAT: begin
					if (in_valid && idx_r == lc_r - 8'h01) begin
						st_r <= SINIT;
					end
				end
				SINIT: st_r <= SRCH;
				SRCH:  st_r <= srch_last ? FIN : SRCH;
				FIN:   st_r <= IDLE;
			endcase
		end
	end

	// Command capture, counters and search walk.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			op_r <= RFA_OP_NONE;
			{tgt_r, nptr_r, phys_r, idx_r, lc_r, le_r} <= '0;
			{pos_r, val_r, pat_len_r, first_r, found_r} <= '0;
			{dir_r, enh_r, occ_r, find_r, le_pres_r, cyc_upd_r} <= '0;
			stat_r <= `RFA_ST_OK;
		end else if (st_r == IDLE && cmd_valid) begin
			op_r      <= cmd_op;
			stat_r    <= dec_st;
			tgt_r     <= dec_tgt;
			nptr_r    <= dec_nptr;
			phys_r    <= to_phys(dec_tgt, newest_r, cnt, file_cyclic);
			cyc_upd_r <= (cmd_op == RFA_OP_UPDATE) && file_cyclic;
			lc_r      <= cmd_lc;
			le_r      <= cmd_le;
			le_pres_r <= cmd_le_present;
			dir_r     <= (mode == `RFA_SRCH_BWD);
			enh_r     <= (mode == `RFA_SRCH_ENH);
			occ_r     <= 1'b0;
			val_r     <= 8'h00;
			idx_r     <= 8'h00;
			pat_len_r <= 8'h00;
			found_r   <= 9'h000;
		end else if (st_r == RD || ((st_r == WR || st_r == PAT) && in_valid))
			begin
			idx_r <= idx_r + 8'h01;
			if (st_r == PAT && enh_r && idx_r == 8'h00) begin
				occ_r <= in_byte[`RFA_IND_OCC_BIT];
				dir_r <= in_byte[`RFA_IND_BWD_BIT];
			end else if (st_r == PAT && enh_r && idx_r == 8'h01) begin
				val_r <= in_byte;
			end else if (st_r == PAT) begin
				pat_len_r <= pat_len_r + 8'h01;
			end
		end else if (st_r == SINIT || (st_r == SRCH && adv)) begin
			// Start of a record: byte one, the offset, or a byte hunt.
			pos_r  <= (enh_r && !occ_r) ? val_r : 8'h00;
			find_r <= enh_r && occ_r;
			if (st_r == SRCH) begin
				tgt_r <= dir_r ? tgt_r - 8'h01 : tgt_r + 8'h01;
			end
			if (found_now) begin
				found_r <= found_r + 9'h001;
				if (found_r == 9'h000) begin
					first_r <= tgt_r;
				end
			end
			if (srch_last) begin
				stat_r <= (found_now || found_r != 9'h000) ?
					`RFA_ST_OK : `RFA_ST_NOT_FOUND;
			end
		end else if (st_r == SRCH) begin
			pos_r <= pos_r + 8'h01;
			if (find_r && cur_byte == val_r) begin
				find_r <= 1'b0; // Matching begins after the byte found.
			end
		end
	end

	// Record pointer and cyclic rotation.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ptr_r    <= `RFA_PTR_UNSET;
			newest_r <= 8'h00;
		end else begin
			if (file_select) begin
				ptr_r <= `RFA_PTR_UNSET;
			end else if (rd_end || wr_end) begin
				ptr_r <= nptr_r;
			end else if (st_r == SRCH && srch_last &&
				(found_now || found_r != 9'h000)) begin
				ptr_r <= (found_r == 9'h000) ? tgt_r : first_r;
			end
			if (wr_end && cyc_upd_r) begin
				newest_r <= phys_r;
			end
		end
	end

	// Record store and pattern buffer writes.
	always_ff @(posedge ref_clk) begin
		if (st_r == WR && in_valid) begin
			mem[to_addr(phys_r, idx_r)] <= in_byte;
		end
		if (st_r == PAT && in_valid && !(enh_r && idx_r < 8'h02)) begin
			pat[pat_len_r[$clog2(MAX_LEN)-1:0]] <= in_byte;
		end
	end

	// Response byte stream: record bytes or found record numbers.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			out_valid_r <= 1'b0;
			out_byte_r  <= 8'h00;
			out_last_r  <= 1'b0;
		end else begin
			out_valid_r <= (st_r == RD) || emit;
			out_byte_r  <= (st_r == RD) ? mem[to_addr(phys_r, idx_r)] : tgt_r;
			out_last_r  <= rd_end;
		end
	end

	assign cmd_ready = (st_r == IDLE);
	assign in_ready  = (st_r == WR) || (st_r == PAT);
	assign out_valid = out_valid_r;
	assign out_byte  = out_byte_r;
	assign out_last  = out_last_r;
	assign done      = (st_r == FIN);
	assign status    = stat_r;
	assign rec_ptr   = ptr_r;
endmodule

// ==== rfa_defines.svh ====
// Constants for the record file access unit.
`ifndef RFA_DEFINES_SVH
`define RFA_DEFINES_SVH
`define RFA_MODE_NEXT    3'h2
`define RFA_MODE_PREV    3'h3
`define RFA_MODE_ABS     3'h4
`define RFA_SRCH_FWD     3'h4
`define RFA_SRCH_BWD     3'h5
`define RFA_SRCH_ENH     3'h6
`define RFA_SRCH_PROP    3'h7
`define RFA_SFI_CURRENT  5'h00
`define RFA_SFI_RFU      5'h1f
`define RFA_PTR_UNSET    8'h00
`define RFA_P1_CURRENT   8'h00
`define RFA_IND_OCC_BIT  3
`define RFA_IND_BWD_BIT  2
`define RFA_ENH_HDR_LEN  8'h02
`define RFA_ST_OK        4'h0
`define RFA_ST_NO_ACCESS 4'h1
`define RFA_ST_NOT_FOUND 4'h2
`define RFA_ST_BAD_P2    4'h3
`define RFA_ST_BAD_LEN   4'h4
`define RFA_ST_BAD_CMD   4'h5
`define RFA_ST_NO_FILE   4'h6
`endif

// ==== rfa_pkg.sv ====
// Types shared by the record file access unit.
package rfa_pkg;
	typedef enum logic [1:0] {
		RFA_OP_READ,
		RFA_OP_UPDATE,
		RFA_OP_SEARCH,
		RFA_OP_NONE
	} rfa_op_t;
	typedef enum logic [2:0] {
		IDLE,
		RD,
		WR,
		PAT,
		SINIT,
		SRCH,
		FIN
	} rfa_state_t;
endpackage

// ==== rfa_term_model.sv ====
// Terminal side model that feeds command data bytes to the unit.
`timescale 1ns/10ps
module rfa_term_model (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       in_ready,
	input  wire logic       done,
	input  wire logic [7:0] first_byte,
	input  wire logic       stall,
	output logic            in_valid,
	output logic [7:0]      in_byte
);
	logic [7:0] idx_r;
	// Byte i of the data field is first_byte plus i; idle shows the inverse.
	assign in_byte = in_valid ? first_byte + idx_r :
		~(first_byte + idx_r);
	// Counts bytes taken within one command.
	always_ff @(posedge ref_clk) begin
		if (!nrst || done)
			idx_r <= #1 8'h00;
		else if (in_valid && in_ready)
			idx_r <= #1 idx_r + 8'h01;
	end
	// A byte is held until taken; a stall drops valid between bytes.
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			in_valid <= #1 1'b0;
		else if (!in_valid || in_ready)
			in_valid <= #1 !(stall && in_valid);
	end
endmodule

// ==== rfa_record_unit_sva.sv ====
// Port checker for the record file access unit.
`timescale 1ns/10ps
`include "rfa_defines.svh"
module rfa_record_unit_sva
	import rfa_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       cmd_valid,
	input wire rfa_op_t    cmd_op,
	input wire logic [7:0] cmd_p2,
	input wire logic [7:0] cmd_lc,
	input wire logic       cmd_le_present,
	input wire logic       cmd_ready,
	input wire logic [4:0] file_short_file_id,
	input wire logic       file_cyclic,
	input wire logic [7:0] file_rec_count,
	input wire logic [7:0] file_rec_len,
	input wire logic       read_allowed,
	input wire logic       update_allowed,
	input wire logic       out_valid,
	input wire logic       out_last,
	input wire logic       done,
	input wire logic [3:0] status,
	input wire logic [7:0] rec_ptr
);
	logic       rd, up;
	logic [7:0] cnt_r;
	logic [4:0] fid;
	// Taken commands aimed at the current file, split by kind.
	assign fid = cmd_p2[7:3];
	assign rd = cmd_valid && cmd_ready && fid == 5'h00 && cmd_op == RFA_OP_READ;
	assign up = cmd_valid && cmd_ready && fid == 5'h00 && cmd_op == RFA_OP_UPDATE;
	// Counts bytes handed out since the last completion.
	always_ff @(posedge ref_clk) begin
		if (!nrst || done)
			cnt_r <= 8'h00;
		else if (out_valid)
			cnt_r <= cnt_r + 8'h01;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// A refused command ends at once with the given code and no data.
	sequence s_err(logic [3:0] c);
		done && status == c && !out_valid;
	endsequence
	// The pointer holds until the command completes.
	sequence s_hold;
		$stable(rec_ptr) throughout (##[0:40] done);
	endsequence
	property p_rd_acc;
		rd && !read_allowed |=> s_err(`RFA_ST_NO_ACCESS);
	endproperty
	a_rd_acc: assert property (p_rd_acc) else $error("read access");
	property p_whole;
		out_last |-> done && cnt_r + 8'h01 == file_rec_len;
	endproperty
	a_whole: assert property (p_whole) else $error("record length");
	property p_abs;
		rd && cmd_p2[2:0] == `RFA_MODE_ABS |=> s_hold;
	endproperty
	a_abs: assert property (p_abs) else $error("pointer moved");
	property p_nxt;
		rd && cmd_p2[2:0] == `RFA_MODE_NEXT && rec_ptr == 8'h00 && read_allowed
		|=> ##[0:40] (done && rec_ptr == 8'h01);
	endproperty
	a_nxt: assert property (p_nxt) else $error("next from unset");
	property p_prv;
		rd && cmd_p2[2:0] == `RFA_MODE_PREV && rec_ptr == 8'h00 && read_allowed
		|=> ##[0:40] (done && rec_ptr == file_rec_count);
	endproperty
	a_prv: assert property (p_prv) else $error("previous from unset");
	property p_sfi;
		cmd_valid && cmd_ready && fid != 5'h00 && fid != 5'h1f
		&& fid != file_short_file_id |=> s_err(`RFA_ST_NO_FILE);
	endproperty
	a_sfi: assert property (p_sfi) else $error("file id");
	property p_cyc;
		up && file_cyclic && update_allowed && cmd_lc == file_rec_len
		&& !cmd_le_present && cmd_p2[2:0] != `RFA_MODE_PREV
		|=> s_err(`RFA_ST_BAD_CMD);
	endproperty
	a_cyc: assert property (p_cyc) else $error("cyclic mode");
	property p_len;
		up && update_allowed && (cmd_lc != file_rec_len || cmd_le_present)
		|=> s_err(`RFA_ST_BAD_LEN);
	endproperty
	a_len: assert property (p_len) else $error("update length");
endmodule
bind rfa_record_unit rfa_record_unit_sva i_rfa_record_unit_sva (.*);

// ==== tb_rfa_record_unit.sv ====
// Testbench for the record file access unit.
`timescale 1ns/10ps
`include "rfa_defines.svh"
module tb_rfa_record_unit import rfa_pkg::*;;
	logic       ref_clk, nrst, cmd_valid, cmd_le_present, cmd_ready;
	logic       file_select, file_cyclic, read_allowed, update_allowed;
	logic       in_valid, in_ready, out_valid, out_last, done, stall;
	rfa_op_t    cmd_op;
	logic [7:0] cmd_p1, cmd_p2, cmd_lc, cmd_le, in_byte, out_byte;
	logic [7:0] file_rec_count, file_rec_len, rec_ptr, first_byte;
	logic [4:0] file_short_file_id;
	logic [3:0] status, st;
	logic [7:0] got[$];
	int         fail_count = 0, checks = 0, cyc_n = 0, r;
	rfa_record_unit #(.MAX_RECS(4), .MAX_LEN(8)) i_rfa_record_unit (.*);
	rfa_term_model i_rfa_term_model (.*);
	// Free running clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 4000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmp4(logic [3:0] e);
		checks++;
		if (st !== e) begin
			fail_count++;
			$display("unexpected status exp %h got %h", e, st);
		end
	endtask
	// Issues one command, collects its output bytes and its status.
	task automatic cmd(rfa_op_t o, logic [7:0] a, b, c, logic lp);
		int n;
		got.delete();
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_p1 = a;
		cmd_p2 = b;
		cmd_lc = c;
		cmd_le_present = lp;
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b0;
		for (n = 0; n < 60; n++) begin
			if (out_valid === 1'b1)
				got.push_back(out_byte);
			if (done === 1'b1)
				break;
			@(posedge ref_clk);
			#1;
		end
		st = status;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic rd(logic [7:0] a, b, bs, n, p);
		cmd(RFA_OP_READ, a, b, 8'h00, 1'b0);
		cmp8("count", n, 8'(got.size()));
		foreach (got[i])
			cmp8("byte", bs + 8'(i), got[i]);
		cmp8("pointer", p, rec_ptr);
	endtask
	task automatic up(logic [7:0] a, b, sd);
		first_byte = sd;
		cmd(RFA_OP_UPDATE, a, b, 8'h03, 1'b0);
	endtask
	task automatic sr(logic [7:0] a, b, sd, logic lp, logic [7:0] n, p);
		first_byte = sd;
		cmd(RFA_OP_SEARCH, a, b, 8'h01, lp);
		cmp8("count", n, 8'(got.size()));
		foreach (got[i])
			cmp8("number", p, got[i]);
		cmp8("pointer", p, rec_ptr);
	endtask
	task automatic sel(logic c);
		file_cyclic = c;
		file_select = 1'b1;
		@(posedge ref_clk);
		#1;
		file_select = 1'b0;
		cmp8("pointer", 8'h00, rec_ptr);
	endtask
	// Main sequence on a four record file of three bytes each.
	initial begin
		{nrst, cmd_valid, cmd_le_present, file_select, stall} = 5'h00;
		{cmd_p1, cmd_p2, cmd_lc, first_byte} = 32'h0;
		cmd_op = RFA_OP_NONE;
		cmd_le = 8'h01;
		file_short_file_id = 5'h05;
		file_cyclic = 1'b0;
		file_rec_count = 8'h04;
		file_rec_len = 8'h03;
		{read_allowed, update_allowed} = 2'h3;
		repeat (3) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		sel(1'b0);
		for (r = 1; r < 5; r++)
			up(8'(r), 8'h04, 8'(r * 16));
		cmp8("pointer", 8'h00, rec_ptr);
		for (r = 1; r < 5; r++)
			rd(8'h00, 8'h02, 8'(r * 16), 8'h03, 8'(r));
		rd(8'h00, 8'h02, 8'h00, 8'h00, 8'h04);
		for (r = 3; r > 0; r--)
			rd(8'h00, 8'h03, 8'(r * 16), 8'h03, 8'(r));
		rd(8'h00, 8'h03, 8'h00, 8'h00, 8'h01);
		rd(8'h03, 8'h04, 8'h30, 8'h03, 8'h01);
		rd(8'h00, 8'h04, 8'h10, 8'h03, 8'h01);
		rd(8'h05, 8'h04, 8'h00, 8'h00, 8'h01);
		cmp4(`RFA_ST_NOT_FOUND);
		read_allowed = 1'b0;
		rd(8'h02, 8'h04, 8'h00, 8'h00, 8'h01);
		cmp4(`RFA_ST_NO_ACCESS);
		read_allowed = 1'b1;
		rd(8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
		cmp4(`RFA_ST_BAD_P2);
		cmd(RFA_OP_READ, 8'h01, 8'h04, 8'h00, 1'b1);
		cmp4(`RFA_ST_BAD_LEN);
		rd(8'h01, 8'h2c, 8'h10, 8'h03, 8'h01);
		rd(8'h01, 8'h34, 8'h00, 8'h00, 8'h01);
		cmp4(`RFA_ST_NO_FILE);
		update_allowed = 1'b0;
		up(8'h02, 8'h04, 8'h99);
		cmp4(`RFA_ST_NO_ACCESS);
		update_allowed = 1'b1;
		cmd(RFA_OP_UPDATE, 8'h02, 8'h04, 8'h02, 1'b0);
		cmp4(`RFA_ST_BAD_LEN);
		cmd(RFA_OP_UPDATE, 8'h02, 8'h04, 8'h03, 1'b1);
		cmp4(`RFA_ST_BAD_LEN);
		rd(8'h02, 8'h04, 8'h20, 8'h03, 8'h01);
		up(8'h00, 8'h02, 8'h50);
		rd(8'h00, 8'h04, 8'h50, 8'h03, 8'h02);
		sel(1'b0);
		rd(8'h00, 8'h03, 8'h40, 8'h03, 8'h04);
		up(8'h00, 8'h02, 8'h70);
		rd(8'h00, 8'h04, 8'h40, 8'h03, 8'h04);
		stall = 1'b1;
		up(8'h00, 8'h03, 8'h60);
		stall = 1'b0;
		rd(8'h00, 8'h04, 8'h60, 8'h03, 8'h03);
		sr(8'h01, 8'h04, 8'h61, 1'b1, 8'h01, 8'h03);
		sr(8'h04, 8'h05, 8'h11, 1'b1, 8'h01, 8'h01);
		sr(8'h01, 8'h04, 8'h77, 1'b1, 8'h00, 8'h01);
		sr(8'h01, 8'h04, 8'h42, 1'b0, 8'h00, 8'h04);
		// Record 2 becomes 08 09 0a; hunt for 09, then match 0a after it.
		up(8'h02, 8'h04, 8'h08);
		cmd(RFA_OP_SEARCH, 8'h01, 8'h06, 8'h03, 1'b1);
		cmp8("count", 8'h01, 8'(got.size()));
		cmp8("number", 8'h02, got[0]);
		cmp8("pointer", 8'h02, rec_ptr);
		cmd(RFA_OP_SEARCH, 8'h01, 8'h07, 8'h01, 1'b1);
		cmp4(`RFA_ST_BAD_CMD);
		sel(1'b1);
		cmd(RFA_OP_UPDATE, 8'h00, 8'h02, 8'h03, 1'b0);
		cmp4(`RFA_ST_BAD_CMD);
		for (r = 0; r < 4; r++)
			up(8'h00, 8'h03, 8'(8'ha0 + r * 16));
		cmp8("pointer", 8'h01, rec_ptr);
		rd(8'h01, 8'h04, 8'hd0, 8'h03, 8'h01);
		rd(8'h00, 8'h03, 8'ha0, 8'h03, 8'h04);
		rd(8'h00, 8'h02, 8'hd0, 8'h03, 8'h01);
		finish_test();
	end
endmodule
